/* File: msq_host.sv */
`timescale 1ns/1ns
module msq_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [3:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels
  output logic [3:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  output logic             rready
);
  // Idle bus at time zero
  initial begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
  end

  // One word write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;  // Released lines lose their value
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask

  // One word read
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end while (!(rvalid && rready));
    d = rdata;
    rready <= 1'b0;
  endtask
endmodule // msq_host

/* File: msq_pkg.sv */
// Function
// - After reset the serial port answers as I2C, whatever protocol is set.
// - Command window lasts 3 ms with quick boot set, else 10 ms.
// - Enter command inside the window puts the device in command mode.
// - Window expiry or leave command starts normal mode and one full cycle.
// - First result written when the initial capacitance calculation ends.
// - Cycle order: wakeup, temperature conversion and calc, capacitance ditto.
// - Resolution codes 0..3 give 8..14 bits, 0.30/1.15/4.50/18.0 ms.
// - Capacitance conversion is temperature time times range multiplier.
// - One mode bit selects periodic update or sleep operation.
// - Sleep mode measures only on request; periodic mode at fixed rate.
// - Sleep interval codes give 0, 5, 25 or 125 ms power-down.
// - Periodic cycle end updates outputs before power-down.
// - Interval expiry starts a new cycle; zero interval runs back to back.
// - Periodic temperature once per six capacitance cycles, else skipped.
// - Capacitance period is conversion plus 0.1 and 0.3 ms plus interval.
// - Temperature calculation takes 0.25 ms after its conversion.
// - Worst-case durations are typical durations scaled by 1.15.
// - All sequencing is timed from a 1.85 MHz oscillator started at reset.
// - Reset release starts the clock generator and the sequencer.
// - Sleep mode stays powered down until another measurement request.
package msq_pkg;
  // Clock and oscillator rates
  localparam int CLK_HZ       = 25_000_000;
  localparam int OSC_HZ       = 1_850_000;
  localparam int RATE_GCD     = 10_000;
  localparam int OSC_INC      = OSC_HZ / RATE_GCD;
  localparam int OSC_MOD      = CLK_HZ / RATE_GCD;
  // Time unit of the sequencer in microseconds
  localparam int T_UNIT_US    = 50;
  localparam int UNIT_HALF    = (OSC_HZ / 1000) * T_UNIT_US * 2 / 1000;
  // Durations in microseconds
  localparam int T_WIN_FAST_US = 3000;
  localparam int T_WIN_SLOW_US = 10000;
  localparam int T_WAKE_US     = 100;
  localparam int T_CCALC_US    = 300;
  localparam int T_TCALC_US    = 250;
  localparam int T_CONV8_US    = 300;
  localparam int T_CONV10_US   = 1150;
  localparam int T_CONV12_US   = 4500;
  localparam int T_CONV14_US   = 18000;
  localparam int T_PD1_US      = 5000;
  localparam int T_PD2_US      = 25000;
  localparam int T_PD3_US      = 125000;
  localparam int WORST_NUM     = 115;
  localparam int WORST_DEN     = 100;
  localparam int TEMP_EVERY    = 6;
  // Register offsets
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_CMD    = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_COUNT  = 4'hc;
  // Config fields
  localparam int CF_QUICK = 0;
  localparam int CF_MODE  = 1;
  localparam int CF_RES   = 2;
  localparam int CF_RANGE = 4;
  localparam int CF_SLEEP = 6;
  localparam int CF_SPI   = 8;
  localparam int CF_WORST = 9;
  localparam int CF_W     = 10;
  localparam logic [9:0] CONFIG_RST = 10'h00e;
  // Command bits
  localparam int CMD_ENTER = 0;
  localparam int CMD_LEAVE = 1;
  localparam int CMD_MEAS  = 2;
  // Status fields
  localparam int ST_CMDMODE = 4;
  localparam int ST_FIRST   = 5;
  localparam int ST_TCNT    = 8;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [3:0] {
    S_WINDOW, S_CMD, S_WAKE, S_TCONV, S_TCALC, S_CCONV, S_CCALC,
    S_PDOWN, S_SLEEP
  } msq_state_type;

  // Temperature conversion time per resolution code
  function automatic int msq_conv_us(input logic [1:0] res);
    case (res)
      2'h0:    msq_conv_us = T_CONV8_US;
      2'h1:    msq_conv_us = T_CONV10_US;
      2'h2:    msq_conv_us = T_CONV12_US;
      default: msq_conv_us = T_CONV14_US;
    endcase
  endfunction

  // Power-down time per sleep interval code
  function automatic int msq_pd_us(input logic [1:0] code);
    case (code)
      2'h0:    msq_pd_us = 0;
      2'h1:    msq_pd_us = T_PD1_US;
      2'h2:    msq_pd_us = T_PD2_US;
      default: msq_pd_us = T_PD3_US;
    endcase
  endfunction

  // Microseconds to units, optionally scaled to worst case
  function automatic logic [15:0] msq_units(input int us, input logic worst);
    int u;
    u = us / T_UNIT_US;
    if (worst) begin
      u = (u * WORST_NUM + WORST_DEN - 1) / WORST_DEN;
    end
    msq_units = 16'(u);
  endfunction
endpackage

/* File: msq_sequencer.sv */
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
module msq_sequencer
  import msq_pkg::*;
#(
  parameter int OSC_STEP    = OSC_INC,
  parameter int UNIT_HALF_N = UNIT_HALF
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Sequencer status
  output logic             serial_i2c,
  output logic             cmd_mode,
  output logic             temp_active,
  output logic             cap_active,
  output logic             powered_down,
  output logic             result_update
);
  msq_time_if tb ();
  msq_state_type state_reg, state_next;
  logic [15:0]     timer_reg, timer_next;
  logic [CF_W-1:0] config_reg;
  logic [2:0]      cmd_reg;
  logic [2:0]      tcnt_reg;
  logic            first_reg;
  logic [15:0]     count_reg;
  logic [3:0]      aw_addr_reg;
  logic            aw_full_reg, w_full_reg;
  logic [31:0]     w_data_reg;
  logic [3:0]      w_strb_reg;

  // Oscillator and unit ticks
  msq_timebase #(.OSC_STEP(OSC_STEP), .UNIT_HALF_N(UNIT_HALF_N)) u_tb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tb      (tb.src)
  );

  // Config fields and phase lengths
  wire       worst     = config_reg[CF_WORST];
  wire       periodic  = config_reg[CF_MODE];
  wire [1:0] res_code  = config_reg[CF_RES +: 2];
  wire [1:0] rng_code  = config_reg[CF_RANGE +: 2];
  wire [1:0] pd_code   = config_reg[CF_SLEEP +: 2];
  wire       phase_end = tb.unit_tick && (timer_reg == 16'h0001);
  wire       cmd_enter = cmd_reg[CMD_ENTER];
  wire       cmd_leave = cmd_reg[CMD_LEAVE];
  wire       cmd_meas  = cmd_reg[CMD_MEAS];
  wire [15:0] len_win   = msq_units(config_reg[CF_QUICK] ?
                           T_WIN_FAST_US : T_WIN_SLOW_US, worst);
  wire [15:0] len_wake  = msq_units(T_WAKE_US, worst);
  wire [15:0] len_tconv = msq_units(msq_conv_us(res_code), worst);
  wire [15:0] len_tcalc = msq_units(T_TCALC_US, worst);
  wire [15:0] len_cconv = msq_units(msq_conv_us(res_code)
                           << rng_code, worst);
  wire [15:0] len_ccalc = msq_units(T_CCALC_US, worst);
  wire [15:0] len_pd    = msq_units(msq_pd_us(pd_code), worst);
  // Window counts up, so a quick-boot bit written late still shortens it
  wire        win_end   = tb.unit_tick
                           && (timer_reg >= len_win - 16'h0001);
  wire        need_temp = first_reg || !periodic
                           || (tcnt_reg == 3'h0);
  wire        cyc_done  = (state_reg == S_CCALC) && phase_end;

  // Sequencer next state and phase timer
  always_comb begin
    state_next = state_reg;
    timer_next = tb.unit_tick ? timer_reg - 16'h0001 : timer_reg;
    case (state_reg)
      S_WINDOW: begin
        timer_next = tb.unit_tick ? timer_reg + 16'h0001 : timer_reg;
        if (cmd_enter) begin
          state_next = S_CMD;
        end else if (win_end) begin
          state_next = S_WAKE;
          timer_next = len_wake;
        end
      end
      S_CMD: begin
        timer_next = timer_reg;
        if (cmd_leave) begin
          state_next = S_WAKE;
          timer_next = len_wake;
        end
      end
      S_WAKE: begin
        if (phase_end && need_temp) begin
          state_next = S_TCONV;
          timer_next = len_tconv;
        end else if (phase_end) begin
          state_next = S_CCONV;
          timer_next = len_cconv;
        end
      end
      S_TCONV: begin
        if (phase_end) begin
          state_next = S_TCALC;
          timer_next = len_tcalc;
        end
      end
      S_TCALC: begin
        if (phase_end) begin
          state_next = S_CCONV;
          timer_next = len_cconv;
        end
      end
      S_CCONV: begin
        if (phase_end) begin
          state_next = S_CCALC;
          timer_next = len_ccalc;
        end
      end
      S_CCALC: begin
        if (phase_end && !periodic) begin
          state_next = S_SLEEP;
        end else if (phase_end && len_pd == 16'h0000) begin
          state_next = S_WAKE;
          timer_next = len_wake;
        end else if (phase_end) begin
          state_next = S_PDOWN;
          timer_next = len_pd;
        end
      end
      S_PDOWN: begin
        if (phase_end) begin
          state_next = S_WAKE;
          timer_next = len_wake;
        end
      end
      S_SLEEP: begin
        timer_next = timer_reg;
        if (cmd_meas) begin
          state_next = S_WAKE;
          timer_next = len_wake;
        end
      end
      default: begin
        state_next = S_WINDOW;
        timer_next = 16'h0000;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_WINDOW;
      timer_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // First-cycle flag and modulo-six counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_reg <= 1'b1;
      tcnt_reg  <= 3'h0;
      count_reg <= 16'h0000;
    end else if (state_reg inside {S_WINDOW, S_CMD}) begin
      first_reg <= 1'b1;
      tcnt_reg  <= 3'h0;
    end else if (cyc_done) begin
      first_reg <= 1'b0;
      tcnt_reg  <= (tcnt_reg == 3'(TEMP_EVERY - 1)) ? 3'h0
                   : tcnt_reg + 3'h1;
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Status outputs follow the next state, result_update follows the cycle end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_i2c    <= 1'b1;
      cmd_mode      <= 1'b0;
      temp_active   <= 1'b0;
      cap_active    <= 1'b0;
      powered_down  <= 1'b0;
      result_update <= 1'b0;
    end else begin
      serial_i2c    <= (state_next inside {S_WINDOW, S_CMD})
                       || !config_reg[CF_SPI];
      cmd_mode      <= state_next == S_CMD;
      temp_active   <= state_next inside {S_TCONV, S_TCALC};
      cap_active    <= state_next inside {S_CCONV, S_CCALC};
      powered_down  <= state_next inside {S_PDOWN, S_SLEEP};
      result_update <= cyc_done;
    end
  end

  // Register bus decode
  wire aw_hs    = s_axi_awvalid && s_axi_awready;
  wire w_hs     = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_full_reg && w_full_reg;
  wire wr_cfg   = do_write && aw_addr_reg == REG_CONFIG;
  wire wr_cmd   = do_write && aw_addr_reg == REG_CMD && w_strb_reg[0];
  wire wr_ok    = aw_addr_reg inside {REG_CONFIG, REG_CMD};
  wire ar_hs    = s_axi_arvalid && s_axi_arready;
  wire [3:0] ar_word = {s_axi_araddr[3:2], 2'h0}; // Byte lane bits ignored
  wire rd_ok    = ar_word inside {REG_CONFIG, REG_CMD,
                                  REG_STATUS, REG_COUNT};
  wire [31:0] status_word = {21'h000000, tcnt_reg, 2'h0, first_reg,
                             state_reg == S_CMD, 4'(state_reg)};
  wire [31:0] rd_mux = (ar_word == REG_CONFIG) ?
                       {22'h000000, config_reg} :
                       (ar_word == REG_STATUS) ? status_word :
                       (ar_word == REG_COUNT) ?
                       {16'h0000, count_reg} : 32'h00000000;

  // Write address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= 4'h0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      if (aw_hs) begin
        aw_addr_reg   <= {s_axi_awaddr[3:2], 2'h0};
        aw_full_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (w_hs) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_full_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register writes and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg   <= CONFIG_RST;
      cmd_reg      <= 3'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else begin
      cmd_reg <= wr_cmd ? w_data_reg[2:0] : 3'h0;
      if (wr_cfg && w_strb_reg[0]) begin
        config_reg[7:0] <= w_data_reg[7:0];
      end
      if (wr_cfg && w_strb_reg[1]) begin
        config_reg[CF_W-1:8] <= w_data_reg[CF_W-1:8];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OK;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? RESP_OK : RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Sequence checks
  sequence leaves_from(msq_state_type s);
    $past(state_reg) == s && state_reg != s;
  endsequence

  chk_i2c_at_boot: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_WINDOW |-> serial_i2c)
    else $error("serial port not in I2C mode during window");
  chk_enter_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_WINDOW && cmd_enter |=> state_reg == S_CMD)
    else $error("enter command did not reach command mode");
  chk_cmd_stays: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_CMD && !cmd_leave |=> state_reg == S_CMD)
    else $error("command mode left without leave command");
  chk_leave_starts: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_CMD && cmd_leave |=> state_reg == S_WAKE
    && timer_reg == len_wake && first_reg)
    else $error("leave command did not start a full cycle");
  chk_phase_order: assert property (@(posedge aclk) disable iff (!aresetn)
    leaves_from(S_TCALC) or leaves_from(S_TCONV) |->
    state_reg inside {S_TCALC, S_CCONV})
    else $error("temperature phase followed by wrong phase");
  chk_cap_length: assert property (@(posedge aclk) disable iff (!aresetn)
    leaves_from(S_TCALC) |-> timer_reg == len_cconv)
    else $error("capacitance conversion length wrong");
  chk_update_end: assert property (@(posedge aclk) disable iff (!aresetn)
    result_update |-> $past(state_reg) == S_CCALC
    && $past(phase_end))
    else $error("result update not at calculation end");
  chk_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_SLEEP && !cmd_meas |=> state_reg == S_SLEEP)
    else $error("sleep mode woke without request");
  chk_temp_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    (leaves_from(S_WAKE) and $past(periodic && !first_reg
    && tcnt_reg != 3'h0)) |-> state_reg == S_CCONV)
    else $error("temperature phase not skipped");
  chk_zero_pd: assert property (@(posedge aclk) disable iff (!aresetn)
    (leaves_from(S_CCALC) and $past(periodic && len_pd == 16'h0000))
    |-> state_reg == S_WAKE)
    else $error("zero interval entered power-down");
endmodule // msq_sequencer

/* File: msq_time_if.sv */
`timescale 1ns/1ns
interface msq_time_if;
  logic osc_tick;
  logic unit_tick;
  modport src (output osc_tick, output unit_tick);
  modport snk (input osc_tick, input unit_tick);
endinterface

/* File: msq_timebase.sv */
`timescale 1ns/1ns
module msq_timebase
  import msq_pkg::*;
#(
  parameter int OSC_STEP  = OSC_INC,
  parameter int UNIT_HALF_N = UNIT_HALF
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Tick outputs
  msq_time_if.src   tb
);
  logic [12:0] acc_reg;
  logic [8:0]  half_reg;
  logic [12:0] acc_sum;
  logic [8:0]  half_sum;
  logic        osc_wrap;
  logic        unit_wrap;

  // Fractional divider sums
  assign acc_sum   = acc_reg + 13'(OSC_STEP);
  assign osc_wrap  = acc_sum >= 13'(OSC_MOD);
  assign half_sum  = half_reg + 9'h002;
  assign unit_wrap = half_sum >= 9'(UNIT_HALF_N);

  // Oscillator starts from zero at reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg     <= 13'h0000;
      half_reg    <= 9'h000;
      tb.osc_tick <= 1'b0;
      tb.unit_tick <= 1'b0;
    end else begin
      acc_reg     <= osc_wrap ? acc_sum - 13'(OSC_MOD) : acc_sum;
      tb.osc_tick <= osc_wrap;
      tb.unit_tick <= osc_wrap && unit_wrap;
      if (osc_wrap) begin
        half_reg <= unit_wrap ? half_sum - 9'(UNIT_HALF_N) : half_sum;
      end
    end
  end
endmodule // msq_timebase

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
  import msq_pkg::*;
  localparam int WU  = T_WAKE_US / T_UNIT_US;
  localparam int TCU = T_TCALC_US / T_UNIT_US;
  localparam int CCU = T_CCALC_US / T_UNIT_US;
  // Clock, reset, bus and status wires
  logic        aclk, aresetn;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv, lfsr_reg;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic        serial_i2c, cmd_mode, temp_active, cap_active;
  logic        powered_down, result_update;
  int          fail_count, n_checks, cyc, t_rel, ncyc;
  int          upd_cnt = 0;
  int          conv_u[4] = '{6, 23, 90, 360};
  int          pd_u[4] = '{0, 100, 500, 2500};

  msq_sequencer #(.OSC_STEP(2500), .UNIT_HALF_N(2)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_i2c(serial_i2c), .cmd_mode(cmd_mode),
    .temp_active(temp_active), .cap_active(cap_active),
    .powered_down(powered_down), .result_update(result_update));

  msq_host u_host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready));

  // Clock
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  // Cycle count and result pulse count
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (!aresetn) upd_cnt <= 0;
    else if (result_update === 1'b1) upd_cnt <= upd_cnt + 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction

  // Worst-case duration in units, rounded up
  function automatic int w(input int u);
    w = (u * 115 + 99) / 100;
  endfunction

  task automatic chk(input string nm, input int e, input int s, input int t);
    n_checks++;
    if (s < e - t || s > e + t) begin
      fail_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, s);
    end
  endtask

  task automatic chkv(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_rel = cyc;
    ncyc = 0;
  endtask

  // Follow one measurement cycle and its power-down
  task automatic meas(input bit et, input int tl, input int cl,
                      input int pu, input int g);
    int n;
    n = 0;
    while (temp_active !== 1'b1 && cap_active !== 1'b1 && n < 5000) begin
      @(negedge aclk);
      n++;
    end
    if (g >= 0) chk("wake", g, n, 1);
    chkv("result", 32'(ncyc), 32'(upd_cnt));
    chkv("temp", 32'(et), 32'(temp_active));
    n = 0;
    while (temp_active === 1'b1 && n < 5000) begin
      @(negedge aclk);
      n++;
    end
    if (et) chk("tlen", tl, n, 1);
    chkv("order", 1'b1, cap_active);
    n = 0;
    while (cap_active === 1'b1 && n < 5000) begin
      @(negedge aclk);
      n++;
    end
    chk("clen", cl, n, 1);
    ncyc++;
    n = 0;
    if (pu < 0) begin
      repeat (300) @(negedge aclk);
      chkv("idle", 3'b100, {powered_down, temp_active, cap_active});
      chkv("result", 32'(ncyc), 32'(upd_cnt));
    end else begin
      while (powered_down === 1'b1 && n < 5000) begin
        @(negedge aclk);
        n++;
      end
      chk("pd", pu, n, 1);
    end
  endtask

  // Periodic operation with a given power-down code
  task automatic periodic(input int code, input int n);
    logic [31:0] cfg;
    int          win;
    do_reset();
    win = (code != 3 ? T_WIN_FAST_US : T_WIN_SLOW_US) / T_UNIT_US;
    cfg = {22'h0, 2'b01, 2'(code), 2'(code), 2'(code), 1'b1,
           1'(code != 3)};
    u_host.wr(REG_CONFIG, cfg);
    chkv("i2c", 1'b1, serial_i2c);
    while (temp_active !== 1'b1 && cyc - t_rel < 400) @(negedge aclk);
    chk("window", win + WU, cyc - t_rel, 2);
    for (int i = 0; i < n; i++) begin
      meas(i % 6 == 0, conv_u[code] + TCU, (conv_u[code] << code) + CCU,
           pd_u[code], i == 0 ? 0 : WU);
      if (i == 0) chkv("spi", 1'b0, serial_i2c);
    end
  endtask

  // Main sequence
  initial begin
    logic [1:0] res, rng;
    aresetn = 1'b0;
    cyc = 0;
    fail_count = 0;
    n_checks = 0;
    lfsr_reg = 32'h06d23700;
    do_reset();
    @(negedge aclk);
    chkv("i2c", 1'b1, serial_i2c);
    chkv("cmdmode", 1'b0, cmd_mode);
    u_host.rd(REG_CONFIG, rv);
    chkv("config", 32'h0000000e, rv);
    chkv("rresp", 32'(RESP_OK), 32'(rresp));
    u_host.wr(REG_COUNT, 32'h0000ffff);
    chkv("bresp", 32'(RESP_ERR), 32'(bresp));
    u_host.rd(REG_COUNT, rv);
    chkv("count_ro", 32'h0, rv);
    u_host.rd(REG_CMD, rv);
    chkv("cmd", 32'h0, rv);
    periodic(0, 2);
    periodic(1, 7);
    u_host.rd(REG_COUNT, rv);
    chkv("count", 32'h7, rv);
    periodic(2, 2);
    periodic(3, 2);
    // Command mode, then sleep operation on request
    do_reset();
    lfsr_reg = lfsr(lfsr_reg);
    res = lfsr_reg[9:8];
    rng = lfsr_reg[13:12];
    u_host.wr(REG_CONFIG, {26'h0, rng, res, 2'b00});
    u_host.wr(REG_CMD, 32'h1);
    repeat (250) @(negedge aclk);
    chkv("cmdmode", 3'b100, {cmd_mode, temp_active, cap_active});
    u_host.rd(REG_STATUS, rv);
    chkv("st_cmd", 1'b1, rv[4]);
    u_host.wr(REG_CMD, 32'h2);
    meas(1, conv_u[res] + TCU, (conv_u[res] << rng) + CCU, -1, -1);
    chkv("cmdmode", 1'b0, cmd_mode);
    u_host.wr(REG_CMD, 32'h4);
    meas(1, conv_u[res] + TCU, (conv_u[res] << rng) + CCU, -1, -1);
    u_host.wr(REG_CONFIG, 32'h00000204);
    u_host.wr(REG_CMD, 32'h4);
    meas(1, w(conv_u[1]) + w(TCU), w(conv_u[1]) + w(CCU), -1, -1);
    report_and_stop();
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    report_and_stop();
  end

  task automatic report_and_stop();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
endmodule // tb
